// *** pwt_defines.svh ***
// Register offsets, field positions, reset values and limits for the position triggers.
`ifndef PWT_DEFINES_SVH
`define PWT_DEFINES_SVH

`define PWT_ADDR_W        8
`define PWT_OFS_CTRL      8'h00
`define PWT_OFS_ROUTE     8'h04
`define PWT_OFS_DOSEL     8'h08
`define PWT_OFS_STATUS    8'h0C
`define PWT_LIN_PAGE      3'h1
`define PWT_ROT_PAGE      3'h2

`define PWT_CTRL_LIN_ACT  0
`define PWT_CTRL_ROT_ACT  4
`define PWT_CTRL_LIN_INV  8
`define PWT_CTRL_ROT_INV  12

`define PWT_CTRL_RST      16'h0000
`define PWT_ROUTE_RST     32'h0000_0000
`define PWT_DOSEL_RST     16'h0000
`define PWT_POS_RST       32'h0000_0000
`define PWT_ANG_RST       16'h0000

`define PWT_ANG_MAX       16'h0708
`define PWT_ANG_MIN       16'hF8F8

`define PWT_RESP_OKAY     2'h0
`define PWT_RESP_SLVERR   2'h2

`endif

// *** pwt_pkg.sv ***
// Types shared by the position trigger files.
package pwt_pkg;

  typedef logic signed [31:0] pwt_pos_t;
  typedef logic signed [15:0] pwt_ang_t;

  typedef enum logic [3:0] {
    PWT_DSEL_OFF   = 4'h0,
    PWT_DSEL_ON    = 4'h1,
    PWT_DSEL_TRIG1 = 4'h2,
    PWT_DSEL_TRIG2 = 4'h3,
    PWT_DSEL_TRIG3 = 4'h4,
    PWT_DSEL_TRIG4 = 4'h5
  } pwt_dsel_e;

endpackage

// *** pwt_window.sv ***
// Window comparator for one trigger channel with an invert option.
`timescale 1ns/1ps
module pwt_window #(
  parameter int W = 32
) (
  input  wire logic                clk,    // Control clock.
  input  wire logic                rst_n,  // Asynchronous reset, active low.
  input  wire logic signed [W-1:0] value,  // Position or angle under test.
  input  wire logic signed [W-1:0] left,   // Left edge of the window.
  input  wire logic signed [W-1:0] right,  // Right edge of the window.
  input  wire logic                invert, // Inverts the profile.
  output logic                     state   // Registered channel state.
);

  // The window holds both edges; an empty window (left above right) is never inside.
  wire below  = value < left;
  wire above  = value > right;
  wire in_win = !below && !above;
  wire next_state = in_win ^ invert;

  // Channel state is registered so that status and routing see a clean level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

endmodule // pwt_window

// *** pwt_position_triggers.sv ***
// Position and rotor window triggers with routing to digital outputs over AXI4-Lite.
//
// Notes on behaviour
// - Four trigger outputs fed from four linear and four rotor channels.
// - A digital output shows a trigger only when its function selects it.
// - Several sources on one trigger output are combined by OR.
// - One trigger output never mixes linear and rotor sources.
// - A source that is not activated cannot drive any trigger output.
// - Each linear channel is one bit computed from the actual position.
// - Position below left edge gives 0, or 1 when inverted.
// - Position above right edge gives 0, or 1 when inverted.
// - Rotor channels follow the encoder angle, repeating every revolution.
// - Angle below left edge gives 0, or 1 when inverted.
// - Angle above right edge gives 0, or 1 when inverted.
// - Rotor edges accept only -180.0 to +180.0 degrees in tenths.
// - Source states and trigger output states are readable as status.
`timescale 1ns/1ps
`include "pwt_defines.svh"
module pwt_position_triggers (
  input  wire logic              CLK,           // Control clock, 50 MHz.
  input  wire logic              RST_N,         // Asynchronous reset, active low.
  input  wire logic [7:0]        S_AXI_AWADDR,  // Write address.
  input  wire logic              S_AXI_AWVALID, // Write address valid.
  output logic                   S_AXI_AWREADY, // Write address ready.
  input  wire logic [31:0]       S_AXI_WDATA,   // Write data.
  input  wire logic [3:0]        S_AXI_WSTRB,   // Write byte strobes.
  input  wire logic              S_AXI_WVALID,  // Write data valid.
  output logic                   S_AXI_WREADY,  // Write data ready.
  output logic [1:0]             S_AXI_BRESP,   // Write response.
  output logic                   S_AXI_BVALID,  // Write response valid.
  input  wire logic              S_AXI_BREADY,  // Write response ready.
  input  wire logic [7:0]        S_AXI_ARADDR,  // Read address.
  input  wire logic              S_AXI_ARVALID, // Read address valid.
  output logic                   S_AXI_ARREADY, // Read address ready.
  output logic [31:0]            S_AXI_RDATA,   // Read data.
  output logic [1:0]             S_AXI_RRESP,   // Read response.
  output logic                   S_AXI_RVALID,  // Read data valid.
  input  wire logic              S_AXI_RREADY,  // Read data ready.
  input  wire pwt_pkg::pwt_pos_t POS_ACTUAL,    // Actual position, same clock domain.
  input  wire pwt_pkg::pwt_ang_t ENC_ANGLE,     // Rotor angle in tenths of a degree.
  output logic [3:0]             TRIG_OUT,      // Trigger output states.
  output logic [3:0]             DOUT           // Digital output levels.
);
  import pwt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic        aw_full;
  logic [7:0]  aw_addr;
  logic        w_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;

  logic [15:0] ctrl;
  logic [31:0] route;
  logic [15:0] dosel;
  pwt_pos_t    lin_left  [4];
  pwt_pos_t    lin_right [4];
  pwt_ang_t    rot_left  [4];
  pwt_ang_t    rot_right [4];

  logic [3:0]  lin_st;
  logic [3:0]  rot_st;
  logic [3:0]  trig;
  logic [3:0]  dout;

  // Byte-lane merge of new write data into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Keeps each trigger output within one group; linear sources take precedence.
  function automatic logic [31:0] route_filter(input logic [31:0] in);
    logic [31:0] r;
    r = in;
    for (int k = 0; k < 4; k++) begin
      if (in[8*k +: 4] != 4'h0) begin
        r[8*k+4 +: 4] = 4'h0;
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake signals.

  // Address and data are taken independently; a new pair waits for the response.
  assign S_AXI_AWREADY = !aw_full && !bvalid;
  assign S_AXI_WREADY  = !w_full && !bvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire wr_fire = aw_full && w_full && !bvalid;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode.

  // Edge registers are paged: channel in address bits 4:3, right edge in bit 2.
  wire [1:0] wr_ch     = aw_addr[4:3];
  wire       wr_right  = aw_addr[2];
  wire       wr_ctrl   = aw_addr == `PWT_OFS_CTRL;
  wire       wr_route  = aw_addr == `PWT_OFS_ROUTE;
  wire       wr_dosel  = aw_addr == `PWT_OFS_DOSEL;
  wire       wr_status = aw_addr == `PWT_OFS_STATUS;
  wire       wr_lin    = aw_addr[7:5] == `PWT_LIN_PAGE;
  wire       wr_rot    = aw_addr[7:5] == `PWT_ROT_PAGE;

  wire [31:0] ctrl_new  = merge({16'h0000, ctrl}, w_data, w_strb);
  wire [31:0] route_new = route_filter(merge(route, w_data, w_strb));
  wire [31:0] dosel_new = merge({16'h0000, dosel}, w_data, w_strb);
  wire [31:0] lin_old   = wr_right ? lin_right[wr_ch] : lin_left[wr_ch];
  wire [31:0] lin_new   = merge(lin_old, w_data, w_strb);
  wire [15:0] rot_old   = wr_right ? rot_right[wr_ch] : rot_left[wr_ch];
  wire [31:0] rot_mrg   = merge({16'h0000, rot_old}, w_data, w_strb);
  wire [15:0] rot_new   = rot_mrg[15:0];

  // Angles outside the -1800 to +1800 range are refused and the old edge stays.
  wire ang_ok = ($signed(rot_new) <= $signed(`PWT_ANG_MAX)) &&
                ($signed(rot_new) >= $signed(`PWT_ANG_MIN));

  wire wr_mapped = wr_ctrl || wr_route || wr_dosel || wr_status || wr_lin || wr_rot;
  wire wr_ok     = wr_mapped && !(wr_rot && !ang_ok);
  wire wr_do     = wr_fire && wr_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel state.

  // Address and data holders; the write lands when both are present.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response is raised the cycle the write lands and held until taken.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid <= 1'b0;
      bresp  <= `PWT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Control, routing and output function registers.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl  <= `PWT_CTRL_RST;
      route <= `PWT_ROUTE_RST;
      dosel <= `PWT_DOSEL_RST;
    end else if (wr_do) begin
      if (wr_ctrl) ctrl <= ctrl_new[15:0];
      if (wr_route) route <= route_new;
      if (wr_dosel) dosel <= dosel_new[15:0];
    end
  end

  // Window edges for the linear and rotor channels.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        lin_left[i]  <= `PWT_POS_RST;
        lin_right[i] <= `PWT_POS_RST;
        rot_left[i]  <= `PWT_ANG_RST;
        rot_right[i] <= `PWT_ANG_RST;
      end
    end else if (wr_do) begin
      if (wr_lin && !wr_right) lin_left[wr_ch] <= lin_new;
      if (wr_lin && wr_right) lin_right[wr_ch] <= lin_new;
      if (wr_rot && !wr_right) rot_left[wr_ch] <= rot_new;
      if (wr_rot && wr_right) rot_right[wr_ch] <= rot_new;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire [1:0]  rd_ch    = S_AXI_ARADDR[4:3];
  wire        rd_right = S_AXI_ARADDR[2];
  wire        rd_lin   = S_AXI_ARADDR[7:5] == `PWT_LIN_PAGE;
  wire        rd_rot   = S_AXI_ARADDR[7:5] == `PWT_ROT_PAGE;
  wire        rd_ctrl  = S_AXI_ARADDR == `PWT_OFS_CTRL;
  wire        rd_route = S_AXI_ARADDR == `PWT_OFS_ROUTE;
  wire        rd_dosel = S_AXI_ARADDR == `PWT_OFS_DOSEL;
  wire        rd_stat  = S_AXI_ARADDR == `PWT_OFS_STATUS;
  wire [31:0] rd_linv  = rd_right ? lin_right[rd_ch] : lin_left[rd_ch];
  wire [15:0] rd_rotv  = rd_right ? rot_right[rd_ch] : rot_left[rd_ch];
  wire [31:0] rd_statv = {16'h0000, dout, trig, rot_st, lin_st};
  wire        rd_hit   = rd_ctrl || rd_route || rd_dosel || rd_stat || rd_lin || rd_rot;

  // Read data selection; rotor edges read back sign-extended.
  wire [31:0] rd_val = rd_ctrl  ? {16'h0000, ctrl} :
                       rd_route ? route :
                       rd_dosel ? {16'h0000, dosel} :
                       rd_stat  ? rd_statv :
                       rd_lin   ? rd_linv :
                       rd_rot   ? {{16{rd_rotv[15]}}, rd_rotv} :
                                  32'h0000_0000;

  // Read data is captured at the address handshake and held until taken.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `PWT_RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_hit ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source channels.

  // Four linear window channels on the actual position and four on the rotor angle.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_src
      pwt_window #(.W(32)) u_lin (
        .clk    (CLK),
        .rst_n  (RST_N),
        .value  (POS_ACTUAL),
        .left   (lin_left[i]),
        .right  (lin_right[i]),
        .invert (ctrl[`PWT_CTRL_LIN_INV + i]),
        .state  (lin_st[i])
      );
      pwt_window #(.W(16)) u_rot (
        .clk    (CLK),
        .rst_n  (RST_N),
        .value  (ENC_ANGLE),
        .left   (rot_left[i]),
        .right  (rot_right[i]),
        .invert (ctrl[`PWT_CTRL_ROT_INV + i]),
        .state  (rot_st[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Trigger outputs and digital output selection.

  generate
    for (genvar k = 0; k < 4; k++) begin : g_out
      // Only activated sources can be routed; the route nibbles stay per group.
      wire [3:0] lin_sel   = route[8*k +: 4] & ctrl[`PWT_CTRL_LIN_ACT +: 4];
      wire [3:0] rot_sel   = route[8*k+4 +: 4] & ctrl[`PWT_CTRL_ROT_ACT +: 4];
      wire       next_trig = (|(lin_sel & lin_st)) || (|(rot_sel & rot_st));
      wire [3:0] fsel      = dosel[4*k +: 4];
      wire [3:0] tidx      = fsel - 4'h2;
      wire       is_trig   = (fsel >= PWT_DSEL_TRIG1) && (fsel <= PWT_DSEL_TRIG4);
      wire       next_dout = (fsel == PWT_DSEL_ON) ? 1'b1 :
                             is_trig ? trig[tidx[1:0]] : 1'b0;

      // Trigger and output levels are registered.
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          trig[k] <= 1'b0;
          dout[k] <= 1'b0;
        end else begin
          trig[k] <= next_trig;
          dout[k] <= next_dout;
        end
      end
    end
  endgenerate

  assign TRIG_OUT = trig;
  assign DOUT     = dout;

endmodule // pwt_position_triggers

// *** pwt_feedback_model.sv ***
// Position feedback source model that presents the actual position and encoder angle.
`timescale 1ns/1ps
module pwt_feedback_model (
  input  wire pwt_pkg::pwt_pos_t pos_req, // Position to present.
  input  wire pwt_pkg::pwt_ang_t ang_req, // Angle to present.
  input  wire logic              clk,     // Control clock.
  output pwt_pkg::pwt_pos_t      pos,     // Actual position.
  output pwt_pkg::pwt_ang_t      ang      // Encoder angle.
);
  import pwt_pkg::*;
  // Feedback is registered like an encoder sample, so it moves only on a clock edge.
  initial begin
    pos = '0;
    ang = '0;
  end
  always @(posedge clk) begin
    pos <= pos_req;
    ang <= ang_req;
  end
endmodule // pwt_feedback_model

// *** pwt_position_triggers_asserts.sv ***
// Checker of bus handshakes and output quiet state of the trigger block.
`timescale 1ns/1ps
`include "pwt_defines.svh"
module pwt_position_triggers_asserts (
  input wire logic        CLK,           // Control clock.
  input wire logic        RST_N,         // Reset, active low.
  input wire logic        S_AXI_AWVALID, // Write address valid.
  input wire logic        S_AXI_AWREADY, // Write address ready.
  input wire logic        S_AXI_WVALID,  // Write data valid.
  input wire logic        S_AXI_WREADY,  // Write data ready.
  input wire logic [1:0]  S_AXI_BRESP,   // Write response.
  input wire logic        S_AXI_BVALID,  // Write response valid.
  input wire logic        S_AXI_BREADY,  // Write response ready.
  input wire logic        S_AXI_ARVALID, // Read address valid.
  input wire logic        S_AXI_ARREADY, // Read address ready.
  input wire logic [31:0] S_AXI_RDATA,   // Read data.
  input wire logic [1:0]  S_AXI_RRESP,   // Read response.
  input wire logic        S_AXI_RVALID,  // Read data valid.
  input wire logic        S_AXI_RREADY,  // Read data ready.
  input wire logic [3:0]  TRIG_OUT,      // Trigger outputs.
  input wire logic [3:0]  DOUT           // Digital outputs.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic wrote;
  // Notes whether any write has been taken since reset; before that nothing is configured.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wrote <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      wrote <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Steps of the two bus transfers.
  sequence s_wr_taken; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_rd_taken; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence s_rd_answer; S_AXI_RVALID && !S_AXI_ARREADY; endsequence
  property p_quiet; !wrote |-> TRIG_OUT == 4'h0 && DOUT == 4'h0; endproperty
  property p_wr_ans; s_wr_taken |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID; endproperty
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  property p_b_drop; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  property p_rd_ans; s_rd_taken |=> s_rd_answer; endproperty
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  property p_r_drop; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID ##1 S_AXI_ARREADY; endproperty
  property p_r_err; S_AXI_RVALID && S_AXI_RRESP == `PWT_RESP_SLVERR |-> S_AXI_RDATA == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("Outputs active before any setting.");
  a_wr_ans: assert property (p_wr_ans) else $error("Write answer late.");
  a_b_hold: assert property (p_b_hold) else $error("Write answer not held.");
  a_b_drop: assert property (p_b_drop) else $error("Write answer not released.");
  a_rd_ans: assert property (p_rd_ans) else $error("Read answer late.");
  a_r_hold: assert property (p_r_hold) else $error("Read answer not held.");
  a_r_drop: assert property (p_r_drop) else $error("Read answer not released.");
  a_r_err: assert property (p_r_err) else $error("Refused read carries data.");
endmodule // pwt_position_triggers_asserts
bind pwt_position_triggers pwt_position_triggers_asserts i_chk (.*);

// *** pwt_position_triggers_bench.sv ***
// Self-checking bench of the position window triggers.
`timescale 1ns/1ps
`include "pwt_defines.svh"
module pwt_position_triggers_bench;
  import pwt_pkg::*;
  logic        CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, route, rq[$];
  logic [3:0]  S_AXI_WSTRB, TRIG_OUT, DOUT;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr[$], bq[$];
  logic [15:0] ctrl, dosel, e;
  pwt_pos_t    POS_ACTUAL, pos_req, lf[4], rt[4];
  pwt_ang_t    ENC_ANGLE, ang_req, alf[4], art[4];
  int          num_errors, n_compared, cyc;
  pwt_position_triggers i_dut (.*);
  pwt_feedback_model i_fb (.clk(CLK), .pos_req(pos_req), .ang_req(ang_req), .pos(POS_ACTUAL),
                           .ang(ENC_ANGLE));
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reference for the status word: channel states, trigger outputs and digital outputs.
  function automatic logic [15:0] exp_st();
    logic [3:0] l, r, t, d;
    for (int i = 0; i < 4; i++) begin
      l[i] = (lf[i] <= pos_req && pos_req <= rt[i]) ^ ctrl[8+i];
      r[i] = (alf[i] <= ang_req && ang_req <= art[i]) ^ ctrl[12+i];
    end
    for (int k = 0; k < 4; k++) t[k] = |(route[8*k+:4] & ctrl[3:0] & l) | |(route[8*k+4+:4] & ctrl[7:4] & r);
    for (int k = 0; k < 4; k++) d[k] = dosel[4*k+:4] == 1 || (dosel[4*k+:4] inside {[2:5]} && t[dosel[4*k+:4]-2]);
    return {d, t, r, l};
  endfunction
  // Mirror of a register write; gives the response the block should return.
  function automatic logic [1:0] upd(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (a == `PWT_OFS_CTRL) ctrl = d[15:0];
    else if (a == `PWT_OFS_DOSEL) dosel = d[15:0];
    else if (a == `PWT_OFS_ROUTE) begin
      for (int k = 0; k < 4; k++) if (d[8*k+:4] != 4'h0) r[8*k+4+:4] = 4'h0;
      route = r;
    end else if (a[7:5] == `PWT_LIN_PAGE) begin
      if (a[2]) rt[a[4:3]] = d; else lf[a[4:3]] = d;
    end else if (a[7:5] == `PWT_ROT_PAGE) begin
      if ($signed(d[15:0]) < $signed(`PWT_ANG_MIN) || $signed(d[15:0]) > $signed(`PWT_ANG_MAX)) return `PWT_RESP_SLVERR;
      if (a[2]) art[a[4:3]] = d[15:0]; else alf[a[4:3]] = d[15:0];
    end else if (a != `PWT_OFS_STATUS) return `PWT_RESP_SLVERR;
    return `PWT_RESP_OKAY;
  endfunction
  // Expected response and data of a register read.
  function automatic logic [33:0] exp_rd(logic [7:0] a);
    pwt_ang_t v;
    v = a[2] ? art[a[4:3]] : alf[a[4:3]];
    if (a == `PWT_OFS_CTRL) return {18'h0, ctrl};
    if (a == `PWT_OFS_ROUTE) return {2'h0, route};
    if (a == `PWT_OFS_DOSEL) return {18'h0, dosel};
    if (a == `PWT_OFS_STATUS) return {18'h0, exp_st()};
    if (a[7:5] == `PWT_LIN_PAGE) return {2'h0, a[2] ? rt[a[4:3]] : lf[a[4:3]]};
    if (a[7:5] == `PWT_ROT_PAGE) return {2'h0, {16{v[15]}}, v};
    return {`PWT_RESP_SLVERR, 32'h0};
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // Bus master: address and data offered together, each released once taken.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bit da, dw, rdy;
    da = 0;
    dw = 0;
    rdy = $urandom_range(0, 1);
    bq.push_back(upd(a, d));
    @(posedge CLK);
    S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1; S_AXI_BREADY <= rdy;
    while (!(da && dw)) begin
      @(posedge CLK);
      if (!da && S_AXI_AWREADY) begin da = 1; S_AXI_AWVALID <= 0; end
      if (!dw && S_AXI_WREADY) begin dw = 1; S_AXI_WVALID <= 0; end
    end
    do @(posedge CLK); while (!S_AXI_BVALID);
    if (!rdy) begin S_AXI_BREADY <= 1; @(posedge CLK); end
    S_AXI_BREADY <= 0;
  endtask
  task automatic rd(logic [7:0] a);
    bit          rdy;
    logic [33:0] x;
    rdy = $urandom_range(0, 1);
    x = exp_rd(a);
    rr.push_back(x[33:32]);
    rq.push_back(x[31:0]);
    @(posedge CLK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= rdy;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 0;
    do @(posedge CLK); while (!S_AXI_RVALID);
    if (!rdy) begin S_AXI_RREADY <= 1; @(posedge CLK); end
    S_AXI_RREADY <= 0;
  endtask
  // Presents one position and angle, lets the pipeline settle, checks ports and status.
  task automatic put(pwt_pos_t p, pwt_ang_t g);
    @(posedge CLK);
    pos_req <= p; ang_req <= g;
    repeat (6) @(posedge CLK);
    e = exp_st();
    chk("TRIG_OUT", TRIG_OUT, e[11:8]);
    chk("DOUT", DOUT, e[15:12]);
    rd(`PWT_OFS_STATUS);
  endtask
  // Scoreboard: each answer on the bus is compared with the oldest note.
  always @(posedge CLK) begin
    if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY) begin
      chk("RDATA", S_AXI_RDATA, rq.pop_front());
      chk("RRESP", S_AXI_RRESP, rr.pop_front());
    end
    if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY) chk("BRESP", S_AXI_BRESP, bq.pop_front());
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 8000) begin num_errors++; end_sim(); end
  end
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, pos_req, ang_req} = '0;
    S_AXI_WSTRB = 4'hF;
    {ctrl, dosel, route} = '0;
    for (int i = 0; i < 4; i++) {lf[i], rt[i], alf[i], art[i]} = '0;
    void'($urandom(32'h68A6));
    RST_N = 0;
    repeat (16) @(posedge CLK);
    RST_N <= 1;
    for (int a = 0; a <= 8'h60; a += 4) rd(8'(a));
    wr(8'h10, 32'h1); wr(`PWT_OFS_STATUS, 32'hFFFF);
    $display("Test reset and map done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h20 + 8 * i, $urandom_range(0, 2000) - 1000);
      wr(8'h24 + 8 * i, lf[i] + (i == 2 ? -5 : 40 * i));
      wr(8'h40 + 8 * i, i == 0 ? -1800 : $urandom_range(0, 1800) - 1800);
      wr(8'h44 + 8 * i, i == 0 ? 1800 : i == 2 ? alf[i] - 1 : alf[i] + $urandom_range(0, 1800));
    end
    wr(8'h44, 1801); wr(8'h40, -1801); rd(8'h40); rd(8'h44);
    $display("Test edges done");
    for (int j = 0; j < 8; j++) begin
      wr(`PWT_OFS_CTRL, $urandom);
      wr(`PWT_OFS_ROUTE, $urandom);
      wr(`PWT_OFS_DOSEL, {4'((j + 6) % 8), 4'((j + 4) % 8), 4'((j + 2) % 8), 4'(j)});
      rd(`PWT_OFS_ROUTE);
      put(lf[j%4] - 1, alf[j%4] - 1);
      put(lf[j%4], alf[j%4]);
      put(rt[j%4], art[j%4]);
      put(rt[j%4] + 1, art[j%4] + 1);
      put($urandom_range(0, 2000) - 1000, $urandom_range(0, 3600) - 1800);
    end
    $display("Test windows and routing done");
    end_sim();
  end
endmodule // pwt_position_triggers_bench
